/* File: ot_fault_pkg.sv */
// Function
// - output over-current warning threshold, read/write
// - over-temperature fault threshold, read/write
// - response 00 keeps output running
// - response 01 runs for delay, then retries
// - response 10 disables output, then retries
// - response 11 stays off until cleared
// - bit clear, clear-all, reset, off/on clear
// - retry 000 never restarts, stays off
// - retry 001-101 restarts that many times
// - restart spacing is delay count times unit
// - every response sets flag and notifies host
// - delay count is two to field power
// - delay unit length comes from outside register
// - retry 110 six times, 111 unlimited
`default_nettype none
package ot_fault_pkg;
    // command codes of the three registers
    localparam logic [7:0]  CODE_OC_WARN_THR = 8'h4A;
    localparam logic [7:0]  CODE_OT_FAULT_THR = 8'h4F;
    localparam logic [7:0]  CODE_OT_ACTION   = 8'h50;
    // reset values: thresholds at largest positive linear value
    localparam logic [15:0] RST_OC_WARN_THR  = 16'h7BFF;
    localparam logic [15:0] RST_OT_FAULT_THR = 16'h7BFF;
    localparam logic [7:0]  RST_OT_ACTION    = 8'h00;
    // field positions inside the action byte
    localparam int          ACT_RESP_HI  = 7;
    localparam int          ACT_RESP_LO  = 6;
    localparam int          ACT_RETRY_HI = 5;
    localparam int          ACT_RETRY_LO = 3;
    localparam int          ACT_DELAY_HI = 2;
    localparam int          ACT_DELAY_LO = 0;
    // response codes
    localparam logic [1:0]  RESP_IGNORE  = 2'h0;
    localparam logic [1:0]  RESP_DELAY   = 2'h1;
    localparam logic [1:0]  RESP_RETRY   = 2'h2;
    localparam logic [1:0]  RESP_LATCH   = 2'h3;
    // retry codes with special meaning
    localparam logic [2:0]  RETRY_NONE    = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER = 3'h7;
    // linear format: 5-bit exponent, 11-bit mantissa, bias keeps shift positive
    localparam int          LIN_EXP_BIAS = 16;
    localparam int          LIN_WIDTH    = 48;

    // converter state machine, one-hot
    typedef enum logic [3:0] {
        ST_RUN     = 4'b0001,  // output follows control pin
        ST_THROUGH = 4'b0010,  // operating through a fault for the delay
        ST_BACKOFF = 4'b0100,  // output off, waiting for next restart
        ST_LATCHED = 4'b1000   // output off until a clearing action
    } conv_state_e;

    // linear value scaled to a common fixed point; both threshold
    // comparisons use it, so mixed exponents compare correctly
    function automatic logic signed [LIN_WIDTH-1:0] lin_val(input logic [15:0] v);
        logic signed [LIN_WIDTH-1:0] mant;
        logic signed [5:0]           expo;
        mant    = LIN_WIDTH'(signed'(v[10:0]));
        expo    = 6'(signed'(v[15:11]));
        lin_val = mant <<< 6'(expo + 6'(LIN_EXP_BIAS));
    endfunction
endpackage
`default_nettype wire

/* File: ot_delay_timer.sv */
`default_nettype none
// counts (2 ** delay field) units of unit_cycles clocks
module ot_delay_timer
    import ot_fault_pkg::*;
#(
    parameter int UNIT_W = 16
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              start,       // one-cycle load pulse
    input  wire logic [2:0]        delay_field, // exponent of unit count
    input  wire logic [UNIT_W-1:0] unit_cycles, // clocks per delay unit
    output logic                   done         // one-cycle pulse at expiry
);
    localparam int CNT_W = UNIT_W + 8;

    initial begin
        if (UNIT_W < 1 || UNIT_W > 24) $error("ot_delay_timer: UNIT_W out of range");
    end

    typedef struct packed {
        logic             running;  // counting toward expiry
        logic [CNT_W-1:0] count;    // clocks left minus one
    } tmr_s;

    tmr_s r;
    tmr_s nxt;
    logic [CNT_W-1:0] total;      // full interval in clocks

    // a zero unit would never expire, so it counts as one clock
    always_comb begin
        total = (unit_cycles == '0) ? CNT_W'(1) : CNT_W'(unit_cycles);
        total = total << delay_field;
    end

    assign done = r.running && (r.count == '0);

    // restart by start wins over expiry of a previous interval
    always_comb begin
        nxt = r;
        if (start) begin
            nxt.running = 1'b1;
            nxt.count   = total - CNT_W'(1);
        end else if (done) begin
            nxt.running = 1'b0;
        end else if (r.running) begin
            nxt.count = r.count - CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end
endmodule
`default_nettype wire

/* File: overtemp_fault_response_ctrl.sv */
`default_nettype none
// over-temperature fault handling and over-current warning of the converter manager
module overtemp_fault_response_ctrl
    import ot_fault_pkg::*;
#(
    parameter int UNIT_W = 16  // width in bits of the delay time unit count, which is counted in clocks
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,          // async, active high; also clears faults
    // command port from the host interface, same clock
    input  wire logic              cmd_wr,       // one-cycle write strobe
    input  wire logic [7:0]        cmd_code,     // register command code
    input  wire logic [15:0]       cmd_wdata,    // write data, low byte for the action byte
    output logic      [15:0]       cmd_rdata,    // registered read of cmd_code
    input  wire logic              clear_all,    // clear-all-faults command pulse
    input  wire logic              clear_ot_bit, // clear of the single fault bit, pulse
    // measurements in linear format, same clock
    input  wire logic [15:0]       temp_meas,
    input  wire logic [15:0]       iout_meas,
    input  wire logic [UNIT_W-1:0] unit_cycles,  // clocks per delay unit
    input  wire logic              op_on,        // on/off command, same clock
    input  wire logic              ctrl_pin,     // control pin, asynchronous
    // results
    output logic                   output_en,    // power stage enable
    output logic                   ot_fault,     // sticky over-temperature flag
    output logic                   oc_warn,      // over-current warning level
    output logic                   host_notify,  // one-cycle pulse on a new fault
    output logic                   latched_off   // level: held off until cleared
);
    initial begin
        if (UNIT_W < 1 || UNIT_W > 24) $error("overtemp_fault_response_ctrl: UNIT_W out of range");
    end

    typedef struct packed {
        conv_state_e state;      // response state
        logic [15:0] oc_thr;     // output over-current warning threshold
        logic [15:0] ot_thr;     // over-temperature fault threshold
        logic [7:0]  action;     // over-temperature fault action byte
        logic [2:0]  attempts;   // restarts already made
        logic        ot_flag;    // sticky fault bit
        logic        oc_flag;    // warning level
        logic        notify;     // notify pulse
        logic        out_en;     // registered enable
        logic        was_on;     // previous combined on command
        logic        pin_s1;     // control pin, first sync stage
        logic        pin_s2;     // control pin, second sync stage
        logic        prev_fault; // fault seen last cycle
        logic [15:0] rdata;      // read data
    } ctl_s;

    ctl_s r;
    ctl_s nxt;

    logic [1:0] resp;        // response field
    logic [2:0] retry_set;   // retry field
    logic [2:0] delay_set;   // delay field
    logic       fault_now;   // comparison result this cycle
    logic       warn_now;    // over-current comparison this cycle
    logic       on_cmd;      // output requested on
    logic       clear_req;   // any clearing action this cycle
    logic       tmr_start;   // load the delay timer
    logic       tmr_done;    // delay timer expired

    assign resp      = r.action[ACT_RESP_HI:ACT_RESP_LO];
    assign retry_set = r.action[ACT_RETRY_HI:ACT_RETRY_LO];
    assign delay_set = r.action[ACT_DELAY_HI:ACT_DELAY_LO];

    // detection: compare decoded linear values, never raw bit patterns
    assign fault_now = lin_val(temp_meas) >= lin_val(r.ot_thr);
    assign warn_now  = lin_val(iout_meas) > lin_val(r.oc_thr);

    // the pin is read only after the second stage
    assign on_cmd = r.pin_s2 && op_on;

    // an off-then-on of the output counts as a clear; so do the commands
    assign clear_req = clear_all || clear_ot_bit || (on_cmd && !r.was_on);

    ot_delay_timer #(
        .UNIT_W (UNIT_W)
    ) u_timer (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .start       (tmr_start),
        .delay_field (delay_set),
        .unit_cycles (unit_cycles),
        .done        (tmr_done)
    );

    always_comb begin
        nxt            = r;
        tmr_start      = 1'b0;
        nxt.pin_s1     = ctrl_pin;
        nxt.pin_s2     = r.pin_s1;
        nxt.was_on     = on_cmd;
        nxt.prev_fault = fault_now;
        nxt.notify     = 1'b0;
        nxt.oc_flag    = warn_now;

        // host writes; unknown codes are ignored
        if (cmd_wr) begin
            if (cmd_code == CODE_OC_WARN_THR) begin
                nxt.oc_thr = cmd_wdata;
            end else if (cmd_code == CODE_OT_FAULT_THR) begin
                nxt.ot_thr = cmd_wdata;
            end else if (cmd_code == CODE_OT_ACTION) begin
                nxt.action = cmd_wdata[7:0];
            end
        end

        // reads; unmapped codes return zero
        if (cmd_code == CODE_OC_WARN_THR) begin
            nxt.rdata = r.oc_thr;
        end else if (cmd_code == CODE_OT_FAULT_THR) begin
            nxt.rdata = r.ot_thr;
        end else if (cmd_code == CODE_OT_ACTION) begin
            nxt.rdata = {8'h00, r.action};
        end else begin
            nxt.rdata = 16'h0000;
        end

        // sticky flag: a fault present in the clear cycle keeps it set
        if (clear_all || clear_ot_bit) begin
            nxt.ot_flag = 1'b0;
        end
        if (fault_now) begin
            nxt.ot_flag = 1'b1;
        end
        // every response code notifies once per new fault
        if (fault_now && !r.prev_fault) begin
            nxt.notify = 1'b1;
        end

        case (r.state)
            ST_RUN: begin
                if (fault_now && on_cmd) begin
                    if (resp == RESP_IGNORE) begin
                        nxt.state = ST_RUN;
                    end else if (resp == RESP_DELAY) begin
                        nxt.state = ST_THROUGH;
                        tmr_start = 1'b1;
                    end else if (resp == RESP_RETRY) begin
                        nxt.attempts = 3'h0;
                        if (retry_set == RETRY_NONE) begin
                            nxt.state = ST_LATCHED;
                        end else begin
                            nxt.state = ST_BACKOFF;
                            tmr_start = 1'b1;
                        end
                    end else begin
                        nxt.state = ST_LATCHED;
                    end
                end
            end
            ST_THROUGH: begin
                // output stays on; judge the fault only when the delay ends
                if (!on_cmd) begin
                    nxt.state = ST_RUN;
                end else if (tmr_done) begin
                    nxt.attempts = 3'h0;
                    if (!fault_now) begin
                        nxt.state = ST_RUN;
                    end else if (retry_set == RETRY_NONE) begin
                        nxt.state = ST_LATCHED;
                    end else begin
                        nxt.state = ST_BACKOFF;
                        tmr_start = 1'b1;
                    end
                end
            end
            ST_BACKOFF: begin
                // each expiry is one restart attempt; a present fault fails it
                if (!on_cmd) begin
                    nxt.state = ST_RUN;
                end else if (tmr_done) begin
                    if (!fault_now) begin
                        nxt.state = ST_RUN;
                    end else if (retry_set == RETRY_FOREVER) begin
                        tmr_start = 1'b1;
                    end else if (r.attempts + 3'h1 >= retry_set) begin
                        nxt.state = ST_LATCHED;
                    end else begin
                        nxt.attempts = r.attempts + 3'h1;
                        tmr_start    = 1'b1;
                    end
                end
            end
            ST_LATCHED: begin
                if (clear_req) begin
                    nxt.state = ST_RUN;
                end
            end
            default: begin
                nxt.state = ST_LATCHED;
            end
        endcase

        // output on only while running or operating through a fault
        nxt.out_en = on_cmd && ((nxt.state == ST_RUN) || (nxt.state == ST_THROUGH));
    end

    // reset clears faults and restores the documented defaults
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            r          <= '0;
            r.state    <= ST_RUN;
            r.oc_thr   <= RST_OC_WARN_THR;
            r.ot_thr   <= RST_OT_FAULT_THR;
            r.action   <= RST_OT_ACTION;
        end else begin
            r <= nxt;
        end
    end

    assign cmd_rdata   = r.rdata;
    assign output_en   = r.out_en;
    assign ot_fault    = r.ot_flag;
    assign oc_warn     = r.oc_flag;
    assign host_notify = r.notify;
    assign latched_off = (r.state == ST_LATCHED);
endmodule
`default_nettype wire

/* File: ot_ctrl_assertions.sv */
`default_nettype none
// watches the converter manager at its ports; shadows of the registers follow host writes
module ot_ctrl_assertions
    import ot_fault_pkg::*;
#(
    parameter int UNIT_W = 16
) (
    input wire logic              sys_clk,
    input wire logic              rst,
    input wire logic              cmd_wr,
    input wire logic [7:0]        cmd_code,
    input wire logic [15:0]       cmd_wdata,
    input wire logic [15:0]       cmd_rdata,
    input wire logic              clear_all,
    input wire logic              clear_ot_bit,
    input wire logic [15:0]       temp_meas,
    input wire logic [15:0]       iout_meas,
    input wire logic [UNIT_W-1:0] unit_cycles,
    input wire logic              op_on,
    input wire logic              ctrl_pin,
    input wire logic              output_en,
    input wire logic              ot_fault,
    input wire logic              oc_warn,
    input wire logic              host_notify,
    input wire logic              latched_off
);
    typedef struct packed {
        logic [15:0] oc_thr;
        logic [15:0] ot_thr;
        logic [7:0]  act;
    } shadow_s;
    shadow_s     sh_r;    // registered copy of the three registers
    shadow_s     sh_nxt;  // copy after this cycle's write
    logic [15:0] rd_exp;  // what a read of cmd_code should give
    // follow writes; unmapped codes leave everything alone
    always_comb begin
        sh_nxt = sh_r;
        rd_exp = 16'h0000;
        if (cmd_wr && cmd_code == CODE_OC_WARN_THR) sh_nxt.oc_thr = cmd_wdata;
        if (cmd_wr && cmd_code == CODE_OT_FAULT_THR) sh_nxt.ot_thr = cmd_wdata;
        if (cmd_wr && cmd_code == CODE_OT_ACTION) sh_nxt.act = cmd_wdata[7:0];
        if (cmd_code == CODE_OC_WARN_THR) rd_exp = sh_r.oc_thr;
        if (cmd_code == CODE_OT_FAULT_THR) rd_exp = sh_r.ot_thr;
        if (cmd_code == CODE_OT_ACTION) rd_exp = {8'h00, sh_r.act};
    end
    // reset restores the design's chosen values
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) sh_r <= '{RST_OC_WARN_THR, RST_OT_FAULT_THR, RST_OT_ACTION};
        else sh_r <= sh_nxt;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // compare only like exponents, where the mantissas order the values directly
    a_read_back: assert property (1'b1 |=> cmd_rdata == $past(rd_exp))
        else $error("read data differs from register");
    a_warn_level: assert property (iout_meas[15:11] == sh_r.oc_thr[15:11] |=>
        oc_warn == ($signed($past(iout_meas[10:0])) > $signed($past(sh_r.oc_thr[10:0]))))
        else $error("warning level wrong");
    a_fault_detect: assert property (temp_meas[15:11] == sh_r.ot_thr[15:11] &&
        $signed(temp_meas[10:0]) >= $signed(sh_r.ot_thr[10:0]) |=> ot_fault)
        else $error("fault not flagged");
    a_notify_pulse: assert property (host_notify |-> ot_fault ##1 !host_notify)
        else $error("notify not a single pulse with flag");
    a_ignore_runs: assert property ($rose(ot_fault) && sh_r.act[7:6] == 2'h0 &&
        output_en && op_on |=> output_en)
        else $error("output dropped on ignored fault");
    a_disable_fast: assert property ($rose(ot_fault) && sh_r.act[7] && $past(output_en) |->
        ##[0:1] !output_en)
        else $error("output not disabled");
    a_no_retry: assert property ($rose(ot_fault) && sh_r.act[7] && sh_r.act[5:3] == 3'h0 &&
        $past(output_en) |-> ##[1:3] latched_off)
        else $error("no latch without retries");
    a_latch_off: assert property (latched_off && $past(latched_off) |-> !output_en)
        else $error("output on while latched");
    a_latch_holds: assert property (latched_off && !clear_all && !clear_ot_bit && op_on &&
        $past(op_on) && ctrl_pin && $past(ctrl_pin) && $past(ctrl_pin, 2) && $past(ctrl_pin, 3) |=> latched_off)
        else $error("latch left without clearing");
    a_clear_exits: assert property (latched_off && (clear_all || clear_ot_bit) |=> !latched_off)
        else $error("clear did not release latch");
    c_latch: cover property ($rose(latched_off));
    c_restart: cover property ($rose(output_en) && sh_r.act[7:6] == 2'h2);
    c_warn: cover property ($rose(oc_warn));
endmodule
bind overtemp_fault_response_ctrl ot_ctrl_assertions #(.UNIT_W(UNIT_W)) i_ot_ctrl_assertions (
    .sys_clk, .rst, .cmd_wr, .cmd_code, .cmd_wdata, .cmd_rdata, .clear_all, .clear_ot_bit,
    .temp_meas, .iout_meas, .unit_cycles, .op_on, .ctrl_pin, .output_en, .ot_fault, .oc_warn,
    .host_notify, .latched_off);
`default_nettype wire

/* File: host_model.sv */
`default_nettype none
// host side: writes limits, reads back, issues clearing actions
module host_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] cmd_rdata,
    output var  logic        cmd_wr,
    output var  logic [7:0]  cmd_code,
    output var  logic [15:0] cmd_wdata,
    output var  logic        clear_all,
    output var  logic        clear_ot_bit,
    output var  logic        op_on
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet bus, output commanded on
    initial begin
        cmd_wr = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
        clear_all = 1'b0;
        clear_ot_bit = 1'b0;
        op_on = 1'b1;
    end
    // one strobe; data inverted afterwards so stale data never looks valid
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(posedge sys_clk) #2;
        cmd_wr = 1'b1;
        cmd_code = code;
        cmd_wdata = data;
        @(posedge sys_clk) #2;
        cmd_wr = 1'b0;
        cmd_wdata = ~data;
    endtask
    // registered answer lands at the edge after the code is shown
    task automatic rd(input logic [7:0] code, output logic [15:0] data);
        @(posedge sys_clk) #2;
        cmd_code = code;
        @(posedge sys_clk) #2;
        data = cmd_rdata;
    endtask
    // 0 clear-all, 1 single bit, 2 off then on
    task automatic clr(input int how);
        @(posedge sys_clk) #2;
        if (how == 0) clear_all = 1'b1;
        else if (how == 1) clear_ot_bit = 1'b1;
        else op_on = 1'b0;
        @(posedge sys_clk) #2;
        clear_all = 1'b0;
        clear_ot_bit = 1'b0;
        op_on = 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: tb.sv */
`default_nettype none
module tb
    import ot_fault_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] THR = 16'h0064;  // fault limit, exponent zero
    localparam logic [15:0] HOT = 16'h0070;
    localparam logic [15:0] COOL = 16'h0050;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] temp_meas = COOL;
    logic [15:0] iout_meas = 16'h0000;
    logic [15:0] unit_cycles = 16'h0002;
    logic        ctrl_pin = 1'b1;
    logic        cmd_wr, clear_all, clear_ot_bit, op_on, output_en, ot_fault, oc_warn, host_notify, latched_off;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, w, rv;
    int          n_errors = 0, checks_done = 0, cyc = 0, seed = 82, n, u = 2, d = 2;
    always #12.5 sys_clk = ~sys_clk;
    host_model i_host_model (.sys_clk, .cmd_rdata, .cmd_wr, .cmd_code, .cmd_wdata, .clear_all, .clear_ot_bit, .op_on);
    overtemp_fault_response_ctrl #(.UNIT_W(16)) i_overtemp_fault_response_ctrl (.sys_clk, .rst, .cmd_wr,
        .cmd_code, .cmd_wdata, .cmd_rdata, .clear_all, .clear_ot_bit, .temp_meas, .iout_meas, .unit_cycles,
        .op_on, .ctrl_pin, .output_en, .ot_fault, .oc_warn, .host_notify, .latched_off);
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // timing is judged within a few cycles of slack for the pipeline stages
    task automatic check_near(input string what, input int exp, input int got);
        checks_done++;
        if (got < exp - 3 || got > exp + 3) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask
    // bounded count of edges until output_en (sel 0) or latched_off shows v
    task automatic wait_for(input int sel, input logic v, output int cnt);
        cnt = 0;
        while (((sel == 0) ? output_en : latched_off) !== v && cnt < 2000) begin
            tick(1);
            cnt++;
        end
        // a wait that runs out is a mismatch of its own
        if (cnt >= 2000) begin
            n_errors++;
            $display("CHECK FAILED wait_for expected %b seen %b", v, ~v);
        end
    endtask
    task automatic arm(input logic [7:0] act);
        unit_cycles = 16'(u);
        i_host_model.wr(CODE_OT_FAULT_THR, THR);
        i_host_model.wr(CODE_OT_ACTION, {8'h00, act});
    endtask
    // k delay periods of 2**d units
    function automatic int span(input int k);
        return k * u * (1 << d);
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        tick(12);
        rst = 1'b0;
        i_host_model.rd(CODE_OC_WARN_THR, rv);
        check("oc thr reset", RST_OC_WARN_THR, rv);
        i_host_model.rd(CODE_OT_ACTION, rv);
        check("action reset", {8'h00, RST_OT_ACTION}, rv);
        w = 16'($random(seed));
        i_host_model.wr(CODE_OT_FAULT_THR, w);
        i_host_model.rd(CODE_OT_FAULT_THR, rv);
        check("ot thr", w, rv);
        i_host_model.rd(8'h4B, rv);
        check("unmapped", 16'h0000, rv);
        $display("test registers done");
        i_host_model.wr(CODE_OC_WARN_THR, 16'h0100);
        for (int k = 0; k < 8; k++) begin
            iout_meas = (k == 0) ? 16'h0100 : {6'h00, 10'($random(seed))};
            tick(2);
            check("oc warn", {15'h0, iout_meas[9:0] > 10'h100}, {15'h0, oc_warn});
            check("run on warn", 16'h0001, {15'h0, output_en});
        end
        $display("test warning done");
        arm(8'h00);
        // the random limit above may have left the flag set; start from clear
        i_host_model.clr(0);
        check("flag cleared", 16'h0000, {15'h0, ot_fault});
        temp_meas = THR;
        tick(1);
        check("notify on fault", 16'h0001, {15'h0, host_notify});
        tick(1);
        check("notify one cycle", 16'h0000, {15'h0, host_notify});
        tick(18);
        check("fault at limit", 16'h0001, {15'h0, ot_fault});
        check("ignore runs", 16'h0001, {15'h0, output_en});
        temp_meas = COOL;
        i_host_model.clr(1);
        check("bit cleared", 16'h0000, {15'h0, ot_fault});
        $display("test ignore done");
        arm({2'h1, 3'h0, 3'(d)});
        temp_meas = HOT;
        wait_for(0, 1'b0, n);
        check_near("run through", span(1), n);
        wait_for(1, 1'b1, n);
        check("latch after delay", 16'h0001, {15'h0, latched_off});
        temp_meas = COOL;
        i_host_model.clr(0);
        wait_for(0, 1'b1, n);
        $display("test run through done");
        for (int r = 1; r <= 6; r++) begin
            u = 2 + ($unsigned($random(seed)) % 3);
            d = $unsigned($random(seed)) % 3;
            arm({2'h2, 3'(r), 3'(d)});
            temp_meas = HOT;
            wait_for(0, 1'b0, n);
            wait_for(1, 1'b1, n);
            check_near("retry span", span(r), n);
            temp_meas = COOL;
            if (r % 4 == 3) begin
                rst = 1'b1;
                tick(1);
                rst = 1'b0;
            end else begin
                i_host_model.clr(r % 4);
            end
            wait_for(0, 1'b1, n);
            check("on after clear", 16'h0001, {15'h0, output_en});
        end
        $display("test retries done");
        u = 2;
        d = 1;
        arm(8'hB9);
        temp_meas = HOT;
        wait_for(0, 1'b0, n);
        tick(100);
        check("endless retry", 16'h0000, {15'h0, latched_off});
        temp_meas = COOL;
        wait_for(0, 1'b1, n);
        check_near("recover", span(1) - (100 % span(1)), n);
        i_host_model.clr(1);
        $display("test endless done");
        arm(8'hC0);
        temp_meas = HOT;
        wait_for(1, 1'b1, n);
        check_near("latch at once", 1, n);
        tick(30);
        check("held off", 16'h0001, {15'h0, latched_off & ~output_en});
        temp_meas = COOL;
        // off and on again through the control pin, two sync stages plus one
        ctrl_pin = 1'b0;
        tick(4);
        ctrl_pin = 1'b1;
        wait_for(0, 1'b1, n);
        check_near("pin clears latch", 3, n);
        $display("test latch done");
        stop_test();
    end
endmodule
`default_nettype wire
